// *** common/rcd_pkg.sv ***
// Purpose: constants and types for the reset cause recorder and debug force-reset block
// Assumes: 10 MHz system bus clock, 8-bit register data, 16-bit register addresses
// Notes: register addresses are placed in the high page of the address map
// Function
// - status register is read-only; flags name the source of the latest reset
// - a debug-forced reset clears every status flag
// - any write to the status address restarts the watchdog, contents unchanged
// - power-on sets power-on bit 7 and low-voltage bit 1, clears the rest
// - enabled low-voltage trip resets, setting only the low-voltage flag
// - other resets set pin, watchdog, opcode, address flags from active sources
// - pin flag bit 6 marks a reset from a low external reset pin
// - watchdog flag bit 5 marks watchdog expiry; blocked while watchdog disabled
// - bad-opcode flag bit 4 marks an illegal or unimplemented opcode reset
// - stop while stop disabled, halt-to-debug while debug disabled, are illegal
// - bad-address flag bit 3 marks access to an unimplemented address
// - program writes to the force-reset register are ignored
// - force-reset register always reads zero
// - debug host writes one to bit 0 of force-reset; device then resets
// - device samples mode-select pin after forced reset: high user, low debug
package rcd_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam logic [15:0] STATUS_ADDR = 16'h1800;
  localparam logic [15:0] FORCE_ADDR = 16'h1801;
  localparam int POR_BIT = 7;
  localparam int PIN_BIT = 6;
  localparam int WDOG_BIT = 5;
  localparam int OPC_BIT = 4;
  localparam int ADR_BIT = 3;
  localparam int LVD_BIT = 1;
  localparam int FORCE_BIT = 0;
  localparam logic [7:0] POR_VAL = 8'h82;
  localparam logic [7:0] LVR_VAL = 8'h02;
  localparam logic [7:0] STATUS_MASK = 8'hfa;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam int CLK_PERIOD_NS = 100;
  localparam int RESET_HOLD_NS = 6400;
  localparam int RESET_HOLD_CYC = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_W = $clog2(RESET_HOLD_CYC + 1);
  localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(RESET_HOLD_CYC - 1);
  localparam int SYNC_W = 2;
  typedef enum logic [1:0] {
    RCD_ST_HOLD,
    RCD_ST_SAMPLE,
    RCD_ST_RUN
  } rcd_state_e;
endpackage : rcd_pkg

// *** logic/rcd_cause_enc.sv ***
// Purpose: qualify reset sources and encode the status flags captured at reset entry
// Assumes: all inputs are on the bus clock
// Notes: force beats low-voltage, which beats the remaining sources
`timescale 1ns/1ps
module rcd_cause_enc
  import rcd_pkg::*;
(
  input wire logic force_i,
  input wire logic lvd_trip_i,
  input wire logic low_voltage_reset_enable_i,
  input wire logic pin_low_i,
  input wire logic watchdog_timeout_i,
  input wire logic watchdog_enable_i,
  input wire logic bad_opcode_i,
  input wire logic stop_exec_i,
  input wire logic stop_enable_i,
  input wire logic halt_exec_i,
  input wire logic debug_mode_enable_i,
  input wire logic bad_address_i,
  output logic [7:0] flags_o,
  output logic req_o
);
  logic low_voltage_reset;
  logic wdog;
  logic opc;
  logic [7:0] other;

  always_comb begin
    low_voltage_reset = lvd_trip_i && low_voltage_reset_enable_i;
    wdog = watchdog_timeout_i && watchdog_enable_i;
    opc = bad_opcode_i || (stop_exec_i && !stop_enable_i) || (halt_exec_i && !debug_mode_enable_i);
    other = ZERO_BYTE;
    other[PIN_BIT] = pin_low_i;
    other[WDOG_BIT] = wdog;
    other[OPC_BIT] = opc;
    other[ADR_BIT] = bad_address_i;
    req_o = force_i || low_voltage_reset || (other != ZERO_BYTE);
    if (force_i) begin
      flags_o = ZERO_BYTE;
    end else if (low_voltage_reset) begin
      flags_o = LVR_VAL;
    end else begin
      flags_o = other;
    end
  end
endmodule : rcd_cause_enc

// *** logic/rcd_reset_cause.sv ***
// Purpose: reset cause status register, debug force-reset control and reset sequencing
// Assumes: program accesses arrive on the bus port, debug-host serial commands arrive
//   already decoded on the debug port, both on the bus clock
// Notes: reset requests are taken only while running; a held source retriggers one running
//   cycle after the hold, so a long pin-low drops reset for one cycle between holds
`timescale 1ns/1ps
module rcd_reset_cause
  import rcd_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic bus_rd_i,
  input wire logic bus_wr_i,
  input wire logic [ADDR_W-1:0] bus_addr_i,
  input wire logic [DATA_W-1:0] bus_wdata_i,
  output logic [DATA_W-1:0] bus_rdata_o,
  input wire logic dbg_rd_i,
  input wire logic dbg_wr_i,
  input wire logic [ADDR_W-1:0] dbg_addr_i,
  input wire logic [DATA_W-1:0] dbg_wdata_i,
  output logic [DATA_W-1:0] dbg_rdata_o,
  input wire logic lvd_trip_i,
  input wire logic low_voltage_reset_enable_i,
  input wire logic reset_pin_n_i,
  input wire logic watchdog_timeout_i,
  input wire logic watchdog_enable_i,
  input wire logic bad_opcode_i,
  input wire logic stop_exec_i,
  input wire logic stop_enable_i,
  input wire logic halt_exec_i,
  input wire logic debug_mode_enable_i,
  input wire logic bad_address_i,
  input wire logic debug_mode_select_pin_i,
  output logic sys_reset_o,
  output logic watchdog_restart_o,
  output logic background_debug_mode_o,
  output logic [DATA_W-1:0] reset_cause_status_o
);
  // pin inputs after synchronisation
  logic [1:0] pins_sync;
  logic pin_low;
  logic mode_pin;

  // decoded accesses
  logic bus_wr_status;
  logic dbg_wr_status;
  logic bus_wr_force;
  logic dbg_force;

  // cause encoder
  logic [7:0] cause_flags;
  logic cause_req;
  logic take_req;

  // sequencer and register state
  rcd_state_e state_q;
  rcd_state_e state_d;
  logic [HOLD_W-1:0] hold_cnt_q;
  logic [HOLD_W-1:0] hold_cnt_d;
  logic [7:0] status_q;
  logic [7:0] status_d;
  logic sys_reset_q;
  logic sys_reset_d;
  logic bdm_q;
  logic bdm_d;
  logic wdog_restart_q;
  logic wdog_restart_d;
  logic [DATA_W-1:0] bus_rdata_q;
  logic [DATA_W-1:0] bus_rdata_d;
  logic [DATA_W-1:0] dbg_rdata_q;
  logic [DATA_W-1:0] dbg_rdata_d;

  // reset pin idles high and mode pin defaults high (user mode)
  rcd_sync #(
    .WIDTH(2),
    .INIT(2'h3)
  ) u_pin_sync (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .async_i({debug_mode_select_pin_i, reset_pin_n_i}),
    .sync_o(pins_sync)
  );

  assign pin_low = !pins_sync[0];
  assign mode_pin = pins_sync[1];

  assign bus_wr_status = bus_wr_i && (bus_addr_i == STATUS_ADDR);
  assign dbg_wr_status = dbg_wr_i && (dbg_addr_i == STATUS_ADDR);
  // program writes to the force register are decoded for the assertions only and drive nothing else
  assign bus_wr_force = bus_wr_i && (bus_addr_i == FORCE_ADDR);
  assign dbg_force = dbg_wr_i && (dbg_addr_i == FORCE_ADDR) && dbg_wdata_i[FORCE_BIT];

  rcd_cause_enc u_cause (
    .force_i(dbg_force),
    .lvd_trip_i(lvd_trip_i),
    .low_voltage_reset_enable_i(low_voltage_reset_enable_i),
    .pin_low_i(pin_low),
    .watchdog_timeout_i(watchdog_timeout_i),
    .watchdog_enable_i(watchdog_enable_i),
    .bad_opcode_i(bad_opcode_i),
    .stop_exec_i(stop_exec_i),
    .stop_enable_i(stop_enable_i),
    .halt_exec_i(halt_exec_i),
    .debug_mode_enable_i(debug_mode_enable_i),
    .bad_address_i(bad_address_i),
    .flags_o(cause_flags),
    .req_o(cause_req)
  );

  assign take_req = (state_q == RCD_ST_RUN) && cause_req;

  // sequencer: capture cause at entry, hold reset, then sample the mode pin
  always_comb begin
    state_d = state_q;
    hold_cnt_d = hold_cnt_q;
    status_d = status_q;
    sys_reset_d = sys_reset_q;
    bdm_d = bdm_q;
    case (state_q)
      RCD_ST_RUN: begin
        if (cause_req) begin
          // written only here; bus writes never reach the flags
          status_d = cause_flags & STATUS_MASK;
          state_d = RCD_ST_HOLD;
          hold_cnt_d = '0;
          sys_reset_d = 1'b1;
        end
      end
      RCD_ST_HOLD: begin
        sys_reset_d = 1'b1;
        if (hold_cnt_q == HOLD_LAST) begin
          state_d = RCD_ST_SAMPLE;
        end else begin
          hold_cnt_d = hold_cnt_q + 1'b1;
        end
      end
      RCD_ST_SAMPLE: begin
        // low selects background debug mode, high selects user mode
        bdm_d = !mode_pin;
        sys_reset_d = 1'b0;
        state_d = RCD_ST_RUN;
      end
      default: begin
        state_d = RCD_ST_HOLD;
        hold_cnt_d = '0;
        sys_reset_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      // rst_n_i is the power-on reset of this block
      state_q <= RCD_ST_HOLD;
      hold_cnt_q <= '0;
      status_q <= POR_VAL;
      sys_reset_q <= 1'b1;
      bdm_q <= 1'b0;
    end else begin
      state_q <= state_d;
      hold_cnt_q <= hold_cnt_d;
      status_q <= status_d;
      sys_reset_q <= sys_reset_d;
      bdm_q <= bdm_d;
    end
  end

  // register reads and the watchdog restart side effect
  always_comb begin
    // any value, from either port; data is deliberately discarded
    wdog_restart_d = bus_wr_status || dbg_wr_status;
    bus_rdata_d = ZERO_BYTE;
    dbg_rdata_d = ZERO_BYTE;
    // force register and unmapped addresses read as zero
    if (bus_rd_i && (bus_addr_i == STATUS_ADDR)) begin
      bus_rdata_d = status_q & STATUS_MASK;
    end
    if (dbg_rd_i && (dbg_addr_i == STATUS_ADDR)) begin
      dbg_rdata_d = status_q & STATUS_MASK;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      wdog_restart_q <= 1'b0;
      bus_rdata_q <= ZERO_BYTE;
      dbg_rdata_q <= ZERO_BYTE;
    end else begin
      wdog_restart_q <= wdog_restart_d;
      bus_rdata_q <= bus_rdata_d;
      dbg_rdata_q <= dbg_rdata_d;
    end
  end

  assign bus_rdata_o = bus_rdata_q;
  assign dbg_rdata_o = dbg_rdata_q;
  assign sys_reset_o = sys_reset_q;
  assign watchdog_restart_o = wdog_restart_q;
  assign background_debug_mode_o = bdm_q;
  assign reset_cause_status_o = status_q;

  // ---- assertions ----
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);

  a_status_ro_write: assert property (
    (bus_wr_status && !take_req) |=> (status_q == $past(status_q))
  ) else $error("status changed on a bus write");

  a_force_clears: assert property (
    (state_q == RCD_ST_RUN && dbg_force) |=> (status_q == ZERO_BYTE) && sys_reset_q
  ) else $error("forced reset did not clear all flags");

  a_wdog_restart: assert property (
    (bus_wr_status || dbg_wr_status) |=> watchdog_restart_o
  ) else $error("status write did not restart watchdog");

  a_restart_cause: assert property (
    watchdog_restart_o |-> $past(bus_wr_status || dbg_wr_status)
  ) else $error("spurious watchdog restart");

  a_lvr_flags: assert property (
    (state_q == RCD_ST_RUN && !dbg_force && lvd_trip_i && low_voltage_reset_enable_i)
      |=> (status_q == LVR_VAL)
  ) else $error("low-voltage reset flags wrong");

  a_pin_flag: assert property (
    (take_req && pin_low && !dbg_force && !(lvd_trip_i && low_voltage_reset_enable_i))
      |=> status_q[PIN_BIT] && !status_q[POR_BIT] && !status_q[LVD_BIT]
  ) else $error("pin reset flag not set");

  a_wdog_flag: assert property (
    $rose(status_q[WDOG_BIT]) |-> $past(watchdog_timeout_i && watchdog_enable_i)
  ) else $error("watchdog flag set without an enabled timeout");

  a_opcode_flag: assert property (
    (take_req && !dbg_force && !(lvd_trip_i && low_voltage_reset_enable_i)
      && ((stop_exec_i && !stop_enable_i) || (halt_exec_i && !debug_mode_enable_i)))
      |=> status_q[OPC_BIT]
  ) else $error("disabled stop or halt did not flag bad opcode");

  a_addr_flag: assert property (
    $rose(status_q[ADR_BIT]) |-> $past(bad_address_i)
  ) else $error("bad-address flag without a cause");

  a_user_force_ign: assert property (
    (state_q == RCD_ST_RUN && bus_wr_force && !cause_req) |=> !sys_reset_q
  ) else $error("program write to force register caused a reset");

  a_bus_force_zero: assert property (
    (bus_rd_i && bus_addr_i == FORCE_ADDR) |=> (bus_rdata_o == ZERO_BYTE)
  ) else $error("program read of force register not zero");

  a_dbg_force_zero: assert property (
    (dbg_rd_i && dbg_addr_i == FORCE_ADDR) |=> (dbg_rdata_o == ZERO_BYTE)
  ) else $error("debug read of force register not zero");

  a_reserved_zero: assert property (
    ((status_q & ~STATUS_MASK) == ZERO_BYTE) && ((bus_rdata_o & ~STATUS_MASK) == ZERO_BYTE)
  ) else $error("reserved status bit reads one");

  a_hold_len: assert property (
    (state_q == RCD_ST_RUN && dbg_force) |=> sys_reset_q [*8] ##0 (state_q == RCD_ST_HOLD)
  ) else $error("forced reset dropped early");

  a_mode_sample: assert property (
    (state_q == RCD_ST_SAMPLE) |=> (background_debug_mode_o == !$past(mode_pin)) && !sys_reset_o
  ) else $error("mode pin not sampled at reset release");

  a_por_value: assert property (
    $rose(rst_n_i) |-> (status_q == POR_VAL) && sys_reset_q && !background_debug_mode_o
  ) else $error("power-on status or reset level wrong");

  a_status_read: assert property (
    (bus_rd_i && bus_addr_i == STATUS_ADDR) |=> (bus_rdata_o == $past(reset_cause_status_o))
  ) else $error("program status read wrong");

  a_dbg_status_read: assert property (
    (dbg_rd_i && dbg_addr_i == STATUS_ADDR) |=> (dbg_rdata_o == $past(reset_cause_status_o))
  ) else $error("debug status read wrong");

  a_status_frozen: assert property (
    (state_q != RCD_ST_RUN) |=> $stable(status_q)
  ) else $error("status changed outside reset entry");

  // reset output follows the sequencer: high in hold and sample, low only while running
  a_reset_level: assert property (
    sys_reset_q == (state_q != RCD_ST_RUN)
  ) else $error("reset output disagrees with sequencer");

  a_hold_exit: assert property (
    (state_q == RCD_ST_HOLD && hold_cnt_q == HOLD_LAST) |=> (state_q == RCD_ST_SAMPLE)
  ) else $error("hold did not end at its last count");

  a_force_zero_ign: assert property (
    (state_q == RCD_ST_RUN && dbg_wr_i && dbg_addr_i == FORCE_ADDR && !dbg_wdata_i[FORCE_BIT] && !cause_req)
      |=> !sys_reset_q
  ) else $error("force write of zero caused a reset");

  a_bdm_frozen: assert property (
    (state_q != RCD_ST_SAMPLE) |=> $stable(background_debug_mode_o)
  ) else $error("mode output changed outside sample");

endmodule : rcd_reset_cause

// *** logic/rcd_sync.sv ***
// Purpose: two-flop synchroniser for pin inputs
// Assumes: single clock, synchronous active-low reset
// Notes: reset value is a parameter so idle-high pins do not glitch at release
`timescale 1ns/1ps
module rcd_sync
  import rcd_pkg::*;
#(
  parameter int WIDTH = SYNC_W,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] stab_q;

  // first stage feeds only the second stage
  for (genvar b = 0; b < WIDTH; b++) begin : g_bit
    always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
        meta_q[b] <= INIT[b];
        stab_q[b] <= INIT[b];
      end else begin
        meta_q[b] <= async_i[b];
        stab_q[b] <= meta_q[b];
      end
    end
  end

  assign sync_o = stab_q;
endmodule : rcd_sync

// *** tb/rcd_dbg_host.sv ***
// Purpose: debug host model issuing decoded serial reads and writes and steering the mode pin
// Assumes: one command per call, strobe high for exactly one bus clock
// Notes: the mode pin keeps the level of the last command, so a forced reset samples it
`timescale 1ns/1ps
module rcd_dbg_host (
  input wire logic clock_i,
  input wire logic [7:0] dbg_rdata_i,
  output logic dbg_rd_o,
  output logic dbg_wr_o,
  output logic [15:0] dbg_addr_o,
  output logic [7:0] dbg_wdata_o,
  output logic mode_pin_o
);
  initial begin
    {dbg_rd_o, dbg_wr_o} = 2'b00;
    dbg_addr_o = 16'h0000;
    dbg_wdata_o = 8'h00;
    mode_pin_o = 1'b1;
  end
  // idle address and data go inverted so a stale value never looks like a command
  task automatic access(input logic w, input logic [15:0] a, input logic [7:0] d, input logic m,
                        output logic [7:0] q);
    @(posedge clock_i);
    dbg_rd_o <= !w;
    dbg_wr_o <= w;
    dbg_addr_o <= a;
    dbg_wdata_o <= d;
    mode_pin_o <= m;
    @(posedge clock_i);
    {dbg_rd_o, dbg_wr_o} <= 2'b00;
    dbg_addr_o <= ~a;
    dbg_wdata_o <= ~d;
    #1 q = dbg_rdata_i;
  endtask : access
endmodule : rcd_dbg_host

// *** tb/tb_top.sv ***
// Purpose: self-checking bench for the reset cause recorder and debug force-reset
// Assumes: debug host model drives the decoded debug port and the mode pin
// Notes: every reset is waited out in full before the status is read back
`timescale 1ns/1ps
module tb_top;
  import rcd_pkg::*;
  logic clock_i, rst_n_i, bus_rd_i, bus_wr_i, dbg_rd_i, dbg_wr_i, lvd_trip_i, low_voltage_reset_enable_i;
  logic reset_pin_n_i, watchdog_timeout_i, watchdog_enable_i, bad_opcode_i, stop_exec_i, stop_enable_i;
  logic halt_exec_i, debug_mode_enable_i, bad_address_i, debug_mode_select_pin_i;
  logic sys_reset_o, watchdog_restart_o, background_debug_mode_o, rs;
  logic [ADDR_W-1:0] bus_addr_i, dbg_addr_i;
  logic [DATA_W-1:0] bus_wdata_i, dbg_wdata_i, bus_rdata_o, dbg_rdata_o, reset_cause_status_o, rv;
  logic [6:0] v;
  logic [3:0] en;
  int fails, checks, exp_status, r, e, k;

  rcd_reset_cause DUT (.clock_i, .rst_n_i, .bus_rd_i, .bus_wr_i, .bus_addr_i, .bus_wdata_i, .bus_rdata_o,
    .dbg_rd_i, .dbg_wr_i, .dbg_addr_i, .dbg_wdata_i, .dbg_rdata_o, .lvd_trip_i, .low_voltage_reset_enable_i,
    .reset_pin_n_i, .watchdog_timeout_i, .watchdog_enable_i, .bad_opcode_i, .stop_exec_i, .stop_enable_i,
    .halt_exec_i, .debug_mode_enable_i, .bad_address_i, .debug_mode_select_pin_i, .sys_reset_o,
    .watchdog_restart_o, .background_debug_mode_o, .reset_cause_status_o);
  rcd_dbg_host host (.clock_i(clock_i), .dbg_rdata_i(dbg_rdata_o), .dbg_rd_o(dbg_rd_i), .dbg_wr_o(dbg_wr_i),
    .dbg_addr_o(dbg_addr_i), .dbg_wdata_o(dbg_wdata_i), .mode_pin_o(debug_mode_select_pin_i));

  task automatic end_of_test();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic wait_rst(input logic lvl);
    for (int i = 0; i < 100 && sys_reset_o !== lvl; i++) begin
      @(posedge clock_i);
      #1;
    end
    if (sys_reset_o !== lvl) begin
      fails++;
      end_of_test();
    end
  endtask : wait_rst

  task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge clock_i);
    bus_rd_i <= !w;
    bus_wr_i <= w;
    bus_addr_i <= a;
    bus_wdata_i <= d;
    @(posedge clock_i);
    bus_rd_i <= 1'b0;
    bus_wr_i <= 1'b0;
    bus_addr_i <= ~a;
    #1 rv = bus_rdata_o;
    rs = watchdog_restart_o;
  endtask : bus

  task automatic check_status(input logic b);
    bus(1'b0, STATUS_ADDR, 8'h00);
    cmp(rv, exp_status[7:0]);
    cmp(reset_cause_status_o, exp_status[7:0]);
    cmp({7'h00, background_debug_mode_o}, {7'h00, b});
  endtask : check_status

  // source vector is {lvd, watchdog, opcode, stop, halt, address, pin}
  task automatic drive(input logic [6:0] s, input logic [3:0] n);
    @(posedge clock_i);
    {lvd_trip_i, watchdog_timeout_i, bad_opcode_i, stop_exec_i, halt_exec_i, bad_address_i} <= s[6:1];
    reset_pin_n_i <= !s[0];
    {low_voltage_reset_enable_i, watchdog_enable_i, stop_enable_i, debug_mode_enable_i} <= n;
  endtask : drive

  // a negative expectation means no reset may follow and the status must stay
  task automatic cause(input logic [6:0] s, input logic [3:0] n, input int x);
    drive(s, n);
    if (x < 0) begin
      repeat (6) @(posedge clock_i);
      #1 cmp({7'h00, sys_reset_o}, 8'h00);
    end else begin
      wait_rst(1'b1);
    end
    drive(7'h00, 4'hf);
    wait_rst(1'b0);
    if (x >= 0) exp_status = x;
    check_status(1'b0);
  endtask : cause

  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  initial begin
    {rst_n_i, bus_rd_i, bus_wr_i, lvd_trip_i, watchdog_timeout_i, bad_opcode_i, stop_exec_i} = '0;
    {halt_exec_i, bad_address_i} = '0;
    {reset_pin_n_i, low_voltage_reset_enable_i, watchdog_enable_i, stop_enable_i, debug_mode_enable_i} = '1;
    bus_addr_i = 16'h0000;
    bus_wdata_i = 8'h00;
    fails = 0;
    checks = 0;
    r = $urandom(32'h37263281);
    repeat (3) @(posedge clock_i);
    rst_n_i <= 1'b1;
    wait_rst(1'b0);
    exp_status = 8'h82;
    check_status(1'b0);
    bus(1'b1, STATUS_ADDR, 8'($urandom));
    cmp({7'h00, rs}, 8'h01);
    check_status(1'b0);
    cmp({7'h00, rs}, 8'h00);
    bus(1'b1, FORCE_ADDR, 8'h01);
    cause(7'h00, 4'hf, -1);
    bus(1'b0, FORCE_ADDR, 8'h00);
    cmp(rv, 8'h00);
    host.access(1'b0, FORCE_ADDR, 8'h00, 1'b1, rv);
    cmp(rv, 8'h00);
    host.access(1'b1, FORCE_ADDR, 8'hfe, 1'b1, rv);
    cause(7'h00, 4'hf, -1);
    for (k = 0; k < 2; k++) begin
      host.access(1'b1, FORCE_ADDR, 8'h01, k[0], rv);
      exp_status = 0;
      wait_rst(1'b1);
      wait_rst(1'b0);
      check_status(!k[0]);
      host.access(1'b0, STATUS_ADDR, 8'h00, 1'b1, rv);
      cmp(rv, 8'h00);
    end
    host.access(1'b1, STATUS_ADDR, 8'($urandom), 1'b1, rv);
    cmp({7'h00, watchdog_restart_o}, 8'h01);
    check_status(1'b0);
    cause(7'h40, 4'hf, 8'h02);
    cause(7'h40, 4'h7, -1);
    cause(7'h62, 4'hf, 8'h02);
    cause(7'h01, 4'hf, 8'h40);
    cause(7'h20, 4'hb, -1);
    cause(7'h08, 4'hd, 8'h10);
    cause(7'h04, 4'he, 8'h10);
    cause(7'h0c, 4'hf, -1);
    for (k = 0; k < 16; k++) begin
      r = $urandom;
      v = {1'b0, r[4:0], 1'b0};
      en = {2'b11, r[6:5]};
      e = (v[5] << 5) | ((v[4] | (v[3] & !en[1]) | (v[2] & !en[0])) << 4) | (v[1] << 3);
      cause(v, en, (e == 0) ? -1 : e);
    end
    // second power-on in mid-run must bring back the power-on flags
    @(posedge clock_i);
    rst_n_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    rst_n_i <= 1'b1;
    wait_rst(1'b0);
    exp_status = 8'h82;
    check_status(1'b0);
    end_of_test();
  end
endmodule : tb_top
